/* logic/rilio_interlock.sv */
`timescale 1ns/100ps
`default_nettype none
module rilio_interlock
    import rilio_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Configuration.
    input wire logic interlock_en,
    input wire logic feedback_en,
    // Conditions.
    input wire logic field_clear,
    input wire logic device_error,
    input wire logic reset_press,
    input wire logic feedback_closed,
    // Results.
    output logic out_on,
    output logic reset_required,
    output logic feedback_error
);
    logic locked_reg;
    logic fb_err_reg;
    logic [FB_CNT_W-1:0] fb_cnt_reg;
    logic fb_bad;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            locked_reg <= 1'b1;
        end else if (!interlock_en) begin
            locked_reg <= 1'b0;
        end else if (!field_clear || device_error) begin
            locked_reg <= 1'b1;
        end else if (reset_press) begin
            locked_reg <= 1'b0;
        end
    end

    // With contactors closed the auxiliary contact is open; a closed contact means dropped out.
    assign fb_bad = feedback_en && (feedback_closed == out_on);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fb_cnt_reg <= FB_ZERO;
        end else if (!fb_bad) begin
            fb_cnt_reg <= FB_ZERO;
        end else if (fb_cnt_reg != FB_LIMIT) begin
            fb_cnt_reg <= fb_cnt_reg + 12'h001;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            fb_err_reg <= 1'b0;
        end else if (fb_cnt_reg == FB_LIMIT) begin
            fb_err_reg <= 1'b1;
        end else if (reset_press && field_clear && !fb_bad) begin
            fb_err_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_on <= 1'b0;
        end else begin
            out_on <= field_clear && !device_error && !fb_err_reg && !locked_reg
                && (fb_cnt_reg != FB_LIMIT);
        end
    end

    assign reset_required = locked_reg && field_clear;
    assign feedback_error = fb_err_reg;
endmodule : rilio_interlock
`default_nettype wire

/* logic/rilio_pkg.sv */
package rilio_pkg;
    localparam int NUM_OUT = 2;
    localparam int NUM_UIO = 4;
    localparam int NUM_PAIR = NUM_UIO / 2;
    localparam int UIO_FN_W = 3;
    localparam logic [2:0] FN_NONE = 3'h0;
    localparam logic [2:0] FN_RESET = 3'h1;
    localparam logic [2:0] FN_FEEDBACK = 3'h2;
    localparam logic [2:0] FN_SLEEP = 3'h3;
    localparam logic [2:0] FN_RESTART = 3'h4;
    localparam logic [2:0] FN_OUT_RESET_REQ = 3'h5;
    localparam logic [2:0] FN_OUT_CONTAM = 3'h6;
    localparam int FB_TIME_US = 300;
    localparam int CLK_MHZ = 10;
    localparam int FB_CYCLES = FB_TIME_US * CLK_MHZ;
    localparam int FB_CNT_W = 12;
    localparam logic [FB_CNT_W-1:0] FB_LIMIT = FB_CYCLES[FB_CNT_W-1:0];
    localparam logic [FB_CNT_W-1:0] FB_ZERO = 12'h000;
endpackage : rilio_pkg

/* logic/rilio_top.sv */
// Function
// - Every safety output has its own restart interlock, enabled by configuration.
// - With interlock on, a field interruption switches the output off.
// - With interlock on, the output stays off after the field clears.
// - With interlock on, output returns on only for a reset press while the field is clear.
// - A reset pressed with an object in the field is ignored.
// - Each universal pin is configured as input or output.
// - Designated pin pairs may act as a dual-channel safety output pair.
// - A universal input takes one function: reset, feedback, sleep or restart.
// - Designated input pairs may form one complementary static control input.
// - A universal output shows an indication only, never a safety function.
// - Feedback monitoring checks the contactors really switch with the outputs.
// - Safety output high means on, low means off on detection or error.
`timescale 1ns/100ps
`default_nettype none
module rilio_top
    import rilio_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Scanner status.
    input wire logic [NUM_OUT-1:0] field_clear,
    input wire logic device_error,
    input wire logic contamination,
    // Configuration.
    input wire logic [NUM_OUT-1:0] interlock_en,
    input wire logic [NUM_UIO-1:0] uio_is_output,
    input wire logic [NUM_PAIR-1:0] pair_is_safety_out,
    input wire logic [NUM_PAIR-1:0] pair_is_control_in,
    input wire logic [NUM_UIO*UIO_FN_W-1:0] uio_function,
    // Dedicated safety outputs.
    output logic [NUM_OUT-1:0] safety_switch_output,
    // Universal pins.
    input wire logic [NUM_UIO-1:0] uio_in,
    output logic [NUM_UIO-1:0] uio_out,
    output logic [NUM_UIO-1:0] uio_oe,
    // Status.
    output logic [NUM_OUT-1:0] reset_required,
    output logic [NUM_OUT-1:0] feedback_error,
    output logic [NUM_PAIR-1:0] control_in_value,
    output logic [NUM_PAIR-1:0] control_in_error,
    output logic sleep_request,
    output logic restart_request
);
    logic [NUM_UIO-1:0] sync1_reg;
    logic [NUM_UIO-1:0] sync2_reg;
    logic [NUM_UIO-1:0] prev_reg;
    logic [NUM_UIO-1:0] in_act;
    logic [NUM_UIO-1:0] out_next;
    logic [NUM_UIO-1:0] out_reg;
    logic [NUM_PAIR-1:0] cv_reg;
    logic [NUM_PAIR-1:0] ce_reg;
    logic sleep_reg;
    logic restart_reg;
    logic reset_level;
    logic reset_level_prev_reg;
    logic reset_press;
    logic feedback_level;
    logic feedback_en;
    logic sleep_level;
    logic restart_level;
    logic any_reset_req;

    // Pins come from outside, so two stages guard against metastability.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_reg <= 4'h0;
            sync2_reg <= 4'h0;
            prev_reg <= 4'h0;
        end else begin
            sync1_reg <= uio_in;
            sync2_reg <= sync1_reg;
            prev_reg <= sync2_reg;
        end
    end

    // A pin is an active input when it is neither an output nor a pair member.
    always_comb begin
        in_act = 4'h0;
        for (int i = 0; i < NUM_UIO; i++) begin
            in_act[i] = !uio_is_output[i] && !pair_is_safety_out[i/2]
                && !pair_is_control_in[i/2];
        end
    end

    always_comb begin
        reset_level = 1'b0;
        feedback_level = 1'b0;
        feedback_en = 1'b0;
        sleep_level = 1'b0;
        restart_level = 1'b0;
        for (int i = 0; i < NUM_UIO; i++) begin
            if (in_act[i]) begin
                unique case (uio_function[i*UIO_FN_W +: UIO_FN_W])
                    FN_RESET: reset_level = reset_level | sync2_reg[i];
                    FN_FEEDBACK: begin
                        feedback_en = 1'b1;
                        feedback_level = feedback_level | sync2_reg[i];
                    end
                    FN_SLEEP: sleep_level = sleep_level | sync2_reg[i];
                    FN_RESTART: restart_level = restart_level | (sync2_reg[i] & !prev_reg[i]);
                    default: ;
                endcase
            end
        end
    end

    // A reset counts only as a press-and-release edge, so a stuck button never releases.
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            reset_level_prev_reg <= 1'b0;
        end else begin
            reset_level_prev_reg <= reset_level;
        end
    end
    assign reset_press = reset_level_prev_reg && !reset_level;

    genvar g;
    generate
        for (g = 0; g < NUM_OUT; g++) begin : g_out
            rilio_interlock u_lock (
                .clk(clk),
                .rst_n(rst_n),
                .interlock_en(interlock_en[g]),
                .feedback_en(feedback_en),
                .field_clear(field_clear[g]),
                .device_error(device_error),
                .reset_press(reset_press & field_clear[g]),
                .feedback_closed(feedback_level),
                .out_on(safety_switch_output[g]),
                .reset_required(reset_required[g]),
                .feedback_error(feedback_error[g])
            );
        end
    endgenerate

    assign any_reset_req = |reset_required;

    always_comb begin
        out_next = 4'h0;
        for (int i = 0; i < NUM_UIO; i++) begin
            if (pair_is_safety_out[i/2]) begin
                out_next[i] = safety_switch_output[(i/2) % NUM_OUT];
            end else if (uio_is_output[i]) begin
                unique case (uio_function[i*UIO_FN_W +: UIO_FN_W])
                    FN_OUT_RESET_REQ: out_next[i] = any_reset_req;
                    FN_OUT_CONTAM: out_next[i] = contamination;
                    default: out_next[i] = 1'b0;
                endcase
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            out_reg <= 4'h0;
        end else begin
            out_reg <= out_next;
        end
    end
    assign uio_out = out_reg;

    always_comb begin
        uio_oe = 4'h0;
        for (int i = 0; i < NUM_UIO; i++) begin
            uio_oe[i] = pair_is_safety_out[i/2]
                || (uio_is_output[i] && !pair_is_control_in[i/2]);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cv_reg <= 2'h0;
            ce_reg <= 2'h0;
        end else begin
            for (int p = 0; p < NUM_PAIR; p++) begin
                cv_reg[p] <= pair_is_control_in[p] & sync2_reg[2*p+1] & !sync2_reg[2*p];
                ce_reg[p] <= pair_is_control_in[p] & (sync2_reg[2*p+1] == sync2_reg[2*p]);
            end
        end
    end
    assign control_in_value = cv_reg;
    assign control_in_error = ce_reg;

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            sleep_reg <= 1'b0;
            restart_reg <= 1'b0;
        end else begin
            sleep_reg <= sleep_level;
            restart_reg <= restart_level;
        end
    end
    assign sleep_request = sleep_reg;
    assign restart_request = restart_reg;
endmodule : rilio_top
`default_nettype wire

/* test/restart_interlock_io_test.sv */
`timescale 1ns/100ps
`default_nettype none
module restart_interlock_io_test;
    import rilio_pkg::*;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic device_error = 1'b0;
    logic contamination = 1'b0;
    logic [1:0] field_clear = 2'b11;
    logic [1:0] interlock_en = 2'b01;
    logic [3:0] uio_is_output = 4'h0;
    logic [1:0] pair_is_safety_out = 2'b00;
    logic [1:0] pair_is_control_in = 2'b00;
    logic [11:0] uio_function = {FN_RESTART, FN_SLEEP, FN_FEEDBACK, FN_RESET};
    logic btn = 1'b0;
    logic weld = 1'b0;
    logic start = 1'b0;
    logic [1:0] ext = 2'b00;
    wire logic [3:0] uio_in;
    logic [1:0] safety_switch_output, reset_required, feedback_error;
    logic [1:0] control_in_value, control_in_error;
    logic [3:0] uio_out, uio_oe;
    logic sleep_request, restart_request, aux, run;
    int n_checks = 0;
    int miscompares = 0;
    int k, mode;
    // Pins 2 and 3 show our own drive while enabled, else the far side.
    assign uio_in = {(uio_oe[3:2] & uio_out[3:2]) | (~uio_oe[3:2] & ext), aux, btn};
    rilio_top i_dut (.*);
    rilio_plant i_plant (.clk(clk), .safety_on(safety_switch_output[0]), .weld(weld),
        .start(start), .aux_closed(aux), .run(run));
    initial begin
        forever #50 clk = ~clk;
    end
    function automatic logic ctl_val(input logic [1:0] a);
        return a == 2'b10;
    endfunction : ctl_val
    task automatic report_and_stop();
        $display("checks %0d miscompares %0d", n_checks, miscompares);
        if (miscompares == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    task automatic chk(input string what, input logic [3:0] exp, input logic [3:0] got);
        n_checks++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask : tick
    // The press only counts on release, so the button is let go here.
    task automatic press();
        btn = 1'b1;
        tick(4);
        btn = 1'b0;
        tick(6);
    endtask : press
    task automatic outs(input logic [1:0] exp);
        chk("outputs", 4'(exp), 4'(safety_switch_output));
    endtask : outs
    initial begin
        #6000000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        void'($urandom(32'h0bb5));
        tick(3);
        rst_n = 1'b1;
        tick(4);
        outs(2'b10);
        chk("reset required", 4'h1, 4'(reset_required));
        press();
        outs(2'b11);
        chk("run", 4'h0, 4'(run));
        start = 1'b1;
        tick(1);
        start = 1'b0;
        tick(1);
        chk("run", 4'h1, 4'(run));
        field_clear = 2'b10;
        tick(2);
        outs(2'b10);
        field_clear = 2'b11;
        tick(4);
        outs(2'b10);
        field_clear = 2'b10;
        press();
        field_clear = 2'b11;
        tick(4);
        outs(2'b10);
        press();
        outs(2'b11);
        field_clear = 2'b01;
        tick(2);
        outs(2'b01);
        field_clear = 2'b11;
        tick(2);
        outs(2'b11);
        device_error = 1'b1;
        tick(2);
        outs(2'b00);
        device_error = 1'b0;
        press();
        outs(2'b11);
        for (k = 0; k < 16; k++) begin
            mode = $urandom % 4;
            ext = 2'($urandom);
            contamination = 1'($urandom);
            uio_is_output = (mode == 2) ? 4'hc : 4'h0;
            pair_is_control_in = (mode == 1) ? 2'b10 : 2'b00;
            pair_is_safety_out = (mode == 3) ? 2'b10 : 2'b00;
            uio_function[11:6] = (mode == 2) ? {FN_OUT_CONTAM, FN_OUT_RESET_REQ}
                : {FN_RESTART, FN_SLEEP};
            tick(5);
            case (mode)
                0: chk("sleep", 4'(ext[0]), {uio_oe[3:2], 1'b0, sleep_request});
                1: chk("control", 4'({ext[0] == ext[1], ctl_val(ext)}),
                    4'({control_in_error[1], control_in_value[1]}));
                2: chk("indicator", {2'b11, contamination, 1'b0},
                    {uio_oe[3:2], uio_out[3:2]});
                default: chk("pair", 4'hf, {uio_oe[3:2], uio_out[3:2]});
            endcase
        end
        uio_is_output = 4'h0;
        pair_is_control_in = 2'b00;
        pair_is_safety_out = 2'b00;
        uio_function[11:6] = {FN_RESTART, FN_SLEEP};
        ext = 2'b00;
        tick(3);
        ext = 2'b10;
        tick(3);
        chk("restart", 4'h1, 4'(restart_request));
        tick(1);
        chk("restart", 4'h0, 4'(restart_request));
        chk("feedback error", 4'h0, 4'(feedback_error));
        weld = 1'b1;
        field_clear = 2'b10;
        for (k = 0; k < 4000 && feedback_error[0] !== 1'b1; k++)
            tick(1);
        chk("feedback error", 4'h1, 4'(feedback_error));
        field_clear = 2'b11;
        press();
        outs(2'b10);
        weld = 1'b0;
        tick(4);
        press();
        outs(2'b11);
        chk("feedback error", 4'h0, 4'(feedback_error));
        uio_is_output = 4'hc;
        uio_function[11:6] = {FN_OUT_CONTAM, FN_OUT_RESET_REQ};
        field_clear = 2'b10;
        tick(2);
        field_clear = 2'b11;
        tick(3);
        chk("indicator", {2'b11, contamination, 1'b1}, {uio_oe[3:2], uio_out[3:2]});
        report_and_stop();
    end
endmodule : restart_interlock_io_test
`default_nettype wire

/* test/rilio_plant.sv */
`timescale 1ns/100ps
`default_nettype none
module rilio_plant (
    // Clock.
    input wire logic clk,
    // Safety output and bench controls.
    input wire logic safety_on,
    input wire logic weld,
    input wire logic start,
    // Contact and machine state.
    output logic aux_closed,
    output logic run
);
    logic [1:0] pull_reg = 2'b00;
    always_ff @(posedge clk) begin
        pull_reg <= {pull_reg[0], safety_on};
    end
    // A welded contactor never drops, so its contact stays open.
    assign aux_closed = weld ? 1'b0 : !pull_reg[1];
    always_ff @(posedge clk) begin
        run <= safety_on && (run || start);
    end
endmodule : rilio_plant
`default_nettype wire

/* test/rilio_props.sv */
`timescale 1ns/100ps
`default_nettype none
module rilio_props
    import rilio_pkg::*;
(
    // Clock and reset.
    input wire logic clk,
    input wire logic rst_n,
    // Inputs.
    input wire logic [NUM_OUT-1:0] field_clear,
    input wire logic device_error,
    input wire logic contamination,
    input wire logic [NUM_OUT-1:0] interlock_en,
    input wire logic [NUM_UIO-1:0] uio_is_output,
    input wire logic [NUM_PAIR-1:0] pair_is_safety_out,
    input wire logic [NUM_PAIR-1:0] pair_is_control_in,
    input wire logic [NUM_UIO*UIO_FN_W-1:0] uio_function,
    input wire logic [NUM_UIO-1:0] uio_in,
    // Outputs.
    input wire logic [NUM_OUT-1:0] safety_switch_output,
    input wire logic [NUM_UIO-1:0] uio_out,
    input wire logic [NUM_UIO-1:0] uio_oe,
    input wire logic [NUM_OUT-1:0] reset_required,
    input wire logic [NUM_OUT-1:0] feedback_error,
    input wire logic [NUM_PAIR-1:0] control_in_value,
    input wire logic [NUM_PAIR-1:0] control_in_error,
    input wire logic sleep_request,
    input wire logic restart_request
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    field_off_a: assert property (!field_clear[0] |=> !safety_switch_output[0])
        else $error("output on after interruption");
    error_off_a: assert property (device_error |=> safety_switch_output == 2'b00)
        else $error("output on during device error");
    lock_holds_a: assert property (reset_required[0] |=> !safety_switch_output[0])
        else $error("output on while reset required");
    clear_rise_a: assert property ($rose(safety_switch_output[0]) |->
        $past(field_clear[0]))
        else $error("output rose with field blocked");
    fb_off_a: assert property (1'b1 |=>
        ($past(feedback_error) & safety_switch_output) == 2'b00)
        else $error("output on with feedback error");
    oe_map_a: assert property (uio_oe == ((uio_is_output
        & ~{{2{pair_is_control_in[1]}}, {2{pair_is_control_in[0]}}})
        | {{2{pair_is_safety_out[1]}}, {2{pair_is_safety_out[0]}}}))
        else $error("pin drive enable wrong");
    ctl_err_a: assert property ((pair_is_control_in[1] && uio_in[3] == uio_in[2]) [*4]
        |-> control_in_error[1]) else $error("equal channels not flagged");
    contam_out_a: assert property ((uio_is_output[3] && !pair_is_safety_out[1]
        && uio_function[11:9] == FN_OUT_CONTAM && contamination) [*2] |-> uio_out[3])
        else $error("contamination indication missing");
    cover property ($rose(safety_switch_output[0]));
    cover property ($rose(feedback_error[0]));
    cover property ($rose(control_in_value[1]));
endmodule : rilio_props
bind rilio_top rilio_props i_props (.*);
`default_nettype wire
